// *** rtl/wse_pkg.sv ***
`default_nettype none
package wse_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int REF_CLK_MHZ = 125;
    localparam int REF_CLK_HZ  = REF_CLK_MHZ * 1000000;

    // Pulse and gap times in microseconds, repeat period in milliseconds, converted to clock cycles.
    localparam int PRE_PULSE_GAP_TIME_US  = 30;
    localparam int FORWARD_PULSE_TIME_US  = 45;
    localparam int REVERSE_PULSE_TIME_US  = 90;
    localparam int FAST_PULSE_TIME_US     = 30;
    localparam int STILL_PULSE_TIME_US    = 1440;
    localparam int STILL_REPEAT_PERIOD_MS = 737;

    localparam int PRE_GAP_CYC = PRE_PULSE_GAP_TIME_US * REF_CLK_MHZ;
    localparam int FWD_CYC     = FORWARD_PULSE_TIME_US * REF_CLK_MHZ;
    localparam int REV_CYC     = REVERSE_PULSE_TIME_US * REF_CLK_MHZ;
    localparam int FAST_CYC    = FAST_PULSE_TIME_US * REF_CLK_MHZ;
    localparam int STILL_CYC   = STILL_PULSE_TIME_US * REF_CLK_MHZ;
    localparam int STILL_PERIOD_CYC = STILL_REPEAT_PERIOD_MS * REF_CLK_MHZ * 1000;

    // ****************************************************************
    // Speed thresholds
    // ****************************************************************
    localparam int RISE_SPEED_THRESHOLD_HZ       = 1000;
    localparam int FALL_SPEED_THRESHOLD_HZ       = 950;
    localparam int SPEED_THRESHOLD_HYSTERESIS_HZ =
        RISE_SPEED_THRESHOLD_HZ - FALL_SPEED_THRESHOLD_HZ;
    localparam int FAST_PULSE_MAX_FREQUENCY_HZ   = 4000;

    // Event spacing in cycles that matches each frequency.
    localparam int RISE_PERIOD_CYC = REF_CLK_HZ / RISE_SPEED_THRESHOLD_HZ;
    localparam int FALL_PERIOD_CYC = REF_CLK_HZ / FALL_SPEED_THRESHOLD_HZ;
    localparam int FAST_MIN_PERIOD_CYC = REF_CLK_HZ / FAST_PULSE_MAX_FREQUENCY_HZ;

    // ****************************************************************
    // Comparator levels in percent of peak-to-peak
    // ****************************************************************
    localparam int OPERATE_LEVEL_PCT = 60;
    localparam int RELEASE_LEVEL_PCT = 40;
    localparam int FULL_SCALE_PCT    = 100;

    // ****************************************************************
    // Widths and types
    // ****************************************************************
    localparam int CNT_W = 28;
    localparam int TMR_W = 18;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_GAP   = 2'h1,
        ST_PULSE = 2'h3
    } wse_state_t;

    typedef enum logic [1:0] {
        PK_FWD   = 2'h0,
        PK_REV   = 2'h1,
        PK_FAST  = 2'h2,
        PK_STILL = 2'h3
    } wse_kind_t;

    typedef struct packed {
        logic      valid;
        wse_kind_t kind;
    } wse_req_t;

endpackage : wse_pkg
`default_nettype wire

// *** rtl/wse_level_comparator.sv ***
`timescale 1ns/1ps
`default_nettype none
module wse_level_comparator #(
    parameter int SAMPLE_W = 12,
    parameter int MIN_SPAN = 16
) (
    input  wire logic                       ref_clk,
    input  wire logic                       arst_n,
    input  wire logic signed [SAMPLE_W-1:0] sample,
    output logic                            level,
    output logic                            operate_pulse
);
    import wse_pkg::*;

    localparam int WW = SAMPLE_W + 9;

    logic signed [SAMPLE_W-1:0] max_ff, nxt_max, min_ff, nxt_min;
    logic                       lvl_ff, nxt_lvl, op_ff, nxt_op;
    logic signed [WW-1:0]       op_thr, rel_thr, span;

    // Level at a given percentage between trough and peak.
    function automatic logic signed [WW-1:0] thresh(input logic signed [WW-1:0] lo,
                                                    input logic signed [WW-1:0] sp,
                                                    input int pct);
        thresh = lo + WW'((sp * pct) / FULL_SCALE_PCT);
    endfunction

    // ****************************************************************
    // Peak tracking and switching
    // ****************************************************************
    // The peak restarts at operate and the trough at release, so each
    // threshold follows the amplitude of the latest half cycle.
    always_comb begin
        span    = WW'(max_ff) - WW'(min_ff);
        op_thr  = thresh(WW'(min_ff), span, OPERATE_LEVEL_PCT);
        rel_thr = thresh(WW'(min_ff), span, RELEASE_LEVEL_PCT);
        nxt_max = (sample > max_ff) ? sample : max_ff;
        nxt_min = (sample < min_ff) ? sample : min_ff;
        nxt_lvl = lvl_ff;
        nxt_op  = 1'b0;
        if (!lvl_ff && span >= WW'(MIN_SPAN) && WW'(sample) >= op_thr) begin
            nxt_lvl = 1'b1;
            nxt_op  = 1'b1;
            nxt_max = sample;
        end else if (lvl_ff && WW'(sample) <= rel_thr) begin
            nxt_lvl = 1'b0;
            nxt_min = sample;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            max_ff <= '0;
            min_ff <= '0;
            lvl_ff <= 1'b0;
            op_ff  <= 1'b0;
        end else begin
            max_ff <= nxt_max;
            min_ff <= nxt_min;
            lvl_ff <= nxt_lvl;
            op_ff  <= nxt_op;
        end
    end

    assign level         = lvl_ff;
    assign operate_pulse = op_ff;

    a_operate_level: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(lvl_ff) |-> $past(WW'(sample) >= op_thr && span >= WW'(MIN_SPAN)))
        else $error("Comparator switched on below the operate level.");

endmodule // wse_level_comparator
`default_nettype wire

// *** rtl/wse_pulse_encoder.sv ***
// Summary of operation
// - Hold output low 30 us before pulses.
// - Slow mode: forward 45 us, reverse 90 us.
// - Fast mode: every event a 30 us pulse.
// - Standstill: 1440 us pulse every 737 ms.
// - Enter fast mode above 1000 Hz rising.
// - Leave fast mode below 950 Hz falling.
// - 50 Hz hysteresis keeps mode stable.
// - Fast pulses continue up to 4 kHz.
// - Events at 60 percent, release 40 percent.
// - Start and stay low until first pulse.
`timescale 1ns/1ps
`default_nettype none
module wse_pulse_encoder #(
    parameter int SAMPLE_W = 12,
    parameter int MIN_SPAN = 16,
    parameter logic [wse_pkg::CNT_W-1:0] STILL_PERIOD = wse_pkg::CNT_W'(wse_pkg::STILL_PERIOD_CYC),
    parameter logic [wse_pkg::CNT_W-1:0] RISE_PERIOD  = wse_pkg::CNT_W'(wse_pkg::RISE_PERIOD_CYC),
    parameter logic [wse_pkg::CNT_W-1:0] FALL_PERIOD  = wse_pkg::CNT_W'(wse_pkg::FALL_PERIOD_CYC),
    parameter logic [wse_pkg::TMR_W-1:0] STILL_WIDTH  = wse_pkg::TMR_W'(wse_pkg::STILL_CYC)
) (
    input  wire logic                       ref_clk,
    input  wire logic                       arst_n,
    input  wire logic signed [SAMPLE_W-1:0] mag_sample_a,
    input  wire logic signed [SAMPLE_W-1:0] mag_sample_b,
    output logic                            cur_high,
    output logic                            fast_mode
);
    import wse_pkg::*;

    localparam logic [TMR_W-1:0] GAP_LAST = TMR_W'(PRE_GAP_CYC - 1);

    // ****************************************************************
    // Magnetic event detection
    // ****************************************************************
    logic [1:0] lvl;
    logic [1:0] op;
    logic signed [SAMPLE_W-1:0] samples [2];

    assign samples[0] = mag_sample_a;
    assign samples[1] = mag_sample_b;

    // One comparator per channel; channel B sets the direction.
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        wse_level_comparator #(
            .SAMPLE_W (SAMPLE_W),
            .MIN_SPAN (MIN_SPAN)
        ) u_cmp (
            .ref_clk       (ref_clk),
            .arst_n        (arst_n),
            .sample        (samples[ch]),
            .level         (lvl[ch]),
            .operate_pulse (op[ch])
        );
    end

    logic evt;
    logic evt_rev;
    assign evt     = op[0];
    assign evt_rev = lvl[1];

    // Last timer count of the pulse, one below its length in cycles, for each kind.
    function automatic logic [TMR_W-1:0] width_last(input wse_kind_t k);
        case (k)
            PK_FWD:   width_last = TMR_W'(FWD_CYC - 1);
            PK_REV:   width_last = TMR_W'(REV_CYC - 1);
            PK_FAST:  width_last = TMR_W'(FAST_CYC - 1);
            PK_STILL: width_last = STILL_WIDTH - TMR_W'(1);
            default:  width_last = TMR_W'(FWD_CYC - 1);
        endcase
    endfunction

    // ****************************************************************
    // Speed mode selection
    // ****************************************************************
    logic [CNT_W-1:0] per_ff, nxt_per;
    logic             fast_ff, nxt_fast;

    // The event spacing is counted in cycles and saturates, so a
    // stopped wheel reads as the slowest possible speed.
    always_comb begin
        nxt_per  = (per_ff == '1) ? per_ff : per_ff + CNT_W'(1);
        nxt_fast = fast_ff;
        if (evt) begin
            nxt_per = '0;
            if (per_ff < RISE_PERIOD) begin
                nxt_fast = 1'b1;
            end else if (per_ff > FALL_PERIOD) begin
                nxt_fast = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            per_ff  <= '1;
            fast_ff <= 1'b0;
        end else begin
            per_ff  <= nxt_per;
            fast_ff <= nxt_fast;
        end
    end

    // ****************************************************************
    // Pulse sequencer
    // ****************************************************************
    wse_state_t       state_ff, nxt_state;
    wse_req_t         pend_ff, nxt_pend;
    wse_kind_t        kind_ff, nxt_kind;
    logic [TMR_W-1:0] tmr_ff, nxt_tmr;
    logic [CNT_W-1:0] still_ff, nxt_still;
    logic             cur_ff, nxt_cur;
    logic             fast_out_ff;

    // One event waits while a pulse is in flight; further events in
    // that time are merged, since the line cannot carry them anyway.
    always_comb begin
        nxt_state = state_ff;
        nxt_pend  = pend_ff;
        nxt_kind  = kind_ff;
        nxt_tmr   = tmr_ff + TMR_W'(1);
        nxt_still = (still_ff >= STILL_PERIOD) ? still_ff : still_ff + CNT_W'(1);
        if (evt) begin
            nxt_pend.valid = 1'b1;
            if (nxt_fast) begin
                nxt_pend.kind = PK_FAST;
            end else begin
                nxt_pend.kind = evt_rev ? PK_REV : PK_FWD;
            end
        end else if (!pend_ff.valid && state_ff == ST_IDLE && still_ff >= STILL_PERIOD) begin
            nxt_pend.valid = 1'b1;
            nxt_pend.kind  = PK_STILL;
        end
        case (state_ff)
            ST_IDLE: begin
                nxt_tmr = '0;
                if (pend_ff.valid) begin
                    nxt_state      = ST_GAP;
                    nxt_kind       = pend_ff.kind;
                    nxt_pend.valid = evt;
                    nxt_still      = '0;
                end
            end
            ST_GAP: begin
                if (tmr_ff == GAP_LAST) begin
                    nxt_state = ST_PULSE;
                    nxt_tmr   = '0;
                end
            end
            ST_PULSE: begin
                if (tmr_ff == width_last(kind_ff)) begin
                    nxt_state = ST_IDLE;
                    nxt_tmr   = '0;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_tmr   = '0;
            end
        endcase
        nxt_cur = (nxt_state == ST_PULSE);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= ST_IDLE;
            pend_ff     <= '0;
            kind_ff     <= PK_FWD;
            tmr_ff      <= '0;
            still_ff    <= '0;
            cur_ff      <= 1'b0;
            fast_out_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            pend_ff     <= nxt_pend;
            kind_ff     <= nxt_kind;
            tmr_ff      <= nxt_tmr;
            still_ff    <= nxt_still;
            cur_ff      <= nxt_cur;
            fast_out_ff <= nxt_fast;
        end
    end

    assign cur_high  = cur_ff;
    assign fast_mode = fast_out_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_gap_done;
        state_ff == ST_GAP && tmr_ff == GAP_LAST;
    endsequence

    a_gap_before_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(cur_ff) |-> $past(state_ff == ST_GAP && tmr_ff == GAP_LAST) && $past(!cur_ff))
        else $error("Pulse started without the full low gap.");

    a_gap_then_high: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_gap_done |=> cur_ff && state_ff == ST_PULSE)
        else $error("Gap ended without the pulse starting.");

    a_slow_widths: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(cur_ff) && (kind_ff == PK_FWD || kind_ff == PK_REV)
        |-> $past(tmr_ff) == ((kind_ff == PK_REV) ? TMR_W'(REV_CYC - 1) : TMR_W'(FWD_CYC - 1)))
        else $error("Direction pulse has the wrong width.");

    a_fast_width: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(cur_ff) && kind_ff == PK_FAST |-> $past(tmr_ff) == TMR_W'(FAST_CYC - 1))
        else $error("Fast pulse has the wrong width.");

    a_still_width: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(cur_ff) && kind_ff == PK_STILL |-> $past(tmr_ff) == STILL_WIDTH - TMR_W'(1))
        else $error("Standstill pulse has the wrong width.");

    a_still_launch: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ST_IDLE && !pend_ff.valid && !evt && still_ff >= STILL_PERIOD
        |=> pend_ff.valid && pend_ff.kind == PK_STILL ##1 state_ff == ST_GAP)
        else $error("Standstill pulse not launched after the repeat period.");

    a_rise_to_fast: assert property (@(posedge ref_clk) disable iff (!arst_n)
        evt && per_ff < RISE_PERIOD |=> fast_ff ##1 fast_mode)
        else $error("Fast mode not entered above the rising threshold.");

    a_fall_to_slow: assert property (@(posedge ref_clk) disable iff (!arst_n)
        evt && per_ff > FALL_PERIOD |=> !fast_ff ##1 !fast_mode)
        else $error("Slow mode not resumed below the falling threshold.");

    a_hyst_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !evt || (per_ff >= RISE_PERIOD && per_ff <= FALL_PERIOD) |=> $stable(fast_ff))
        else $error("Speed mode changed inside the hysteresis band.");

    a_fast_sustain: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fast_ff && evt && per_ff <= FALL_PERIOD |=> fast_ff)
        else $error("Fast mode dropped while the wheel is still fast.");

    a_low_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff != ST_PULSE |-> !cur_ff)
        else $error("Output high outside a pulse.");

endmodule // wse_pulse_encoder
`default_nettype wire

// *** tb/wse_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module wse_rx_model #(
    parameter int STILL_W = wse_pkg::STILL_CYC,
    parameter int SETTLE  = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        cur_high,
    output logic [15:0]      pulse_cnt_ff,
    output logic [31:0]      width_ff,
    output logic [31:0]      period_ff,
    output wse_pkg::wse_kind_t kind_ff
);
    import wse_pkg::*;

    // ****************************************************************
    // Pulse timing receiver
    // ****************************************************************
    logic [31:0] run_ff;    // Cycles since the last rising edge.
    logic [31:0] hi_ff;     // Cycles high in the current pulse.
    logic [15:0] settle_ff; // Cycles seen since reset, up to SETTLE.
    logic        prev_ff;

    // width window classing
    // Fast and forward windows end halfway to the next nominal width; standstill is within 15 percent.
    function automatic wse_kind_t classify(input logic [31:0] w);
        if (w * 20 >= STILL_W * 17 && w * 20 <= STILL_W * 23) return PK_STILL;
        if (w < (FAST_CYC + FWD_CYC) / 2) return PK_FAST;
        if (w < (FWD_CYC + REV_CYC) / 2) return PK_FWD;
        if (w < 2 * REV_CYC) return PK_REV;
        return PK_STILL;
    endfunction

    // Times each pulse and the spacing of rising edges.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_ff       <= '0;
            hi_ff        <= '0;
            settle_ff    <= '0;
            prev_ff      <= 1'b0;
            pulse_cnt_ff <= '0;
            width_ff     <= '0;
            period_ff    <= '0;
            kind_ff      <= PK_FWD;
        end else if (settle_ff < 16'(SETTLE)) begin
            settle_ff <= settle_ff + 16'h1;
            prev_ff   <= cur_high;
        end else begin
            prev_ff <= cur_high;
            run_ff  <= (cur_high && !prev_ff) ? 32'h1 : run_ff + 32'h1;
            hi_ff   <= cur_high ? hi_ff + 32'h1 : 32'h0;
            if (cur_high && !prev_ff) begin
                period_ff <= run_ff;
            end
            if (!cur_high && prev_ff) begin
                width_ff     <= hi_ff;
                kind_ff      <= classify(hi_ff);
                pulse_cnt_ff <= pulse_cnt_ff + 16'h1;
            end
        end
    end
endmodule // wse_rx_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wse_pkg::*;

    // ****************************************************************
    // Settings and signals
    // ****************************************************************
    // Short standstill and threshold timing keep the run near 110k cycles.
    // The repeat period must exceed the longest slow event spacing used.
    localparam int STILL_P = 15700;
    localparam int STILL_W = 200;
    localparam logic signed [11:0] HI = 12'sh1f4;
    localparam logic signed [11:0] LO = -12'sh1f4;

    logic               ref_clk;
    logic               arst_n;
    logic signed [11:0] mag_a;
    logic signed [11:0] mag_b;
    logic               cur_high;
    logic               fast_mode;
    logic [15:0]        pulse_cnt;
    logic [31:0]        width;
    logic [31:0]        period;
    wse_kind_t          kind;
    int                 error_cnt;
    int                 samples_checked;
    int                 elapsed;

    wse_pulse_encoder #(
        .STILL_PERIOD (28'(STILL_P)),
        .RISE_PERIOD  (28'h2710),
        .FALL_PERIOD  (28'h2904),
        .STILL_WIDTH  (18'(STILL_W))
    ) dut (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .mag_sample_a (mag_a),
        .mag_sample_b (mag_b),
        .cur_high     (cur_high),
        .fast_mode    (fast_mode)
    );

    wse_rx_model #(
        .STILL_W      (STILL_W)
    ) rx (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .cur_high     (cur_high),
        .pulse_cnt_ff (pulse_cnt),
        .width_ff     (width),
        .period_ff    (period),
        .kind_ff      (kind)
    );

    // Free running 125 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A wait that runs out is a mismatch and ends the run.
    task automatic expire();
        check(32'h0, 32'h1);
        wrap_up();
    endtask

    task automatic tick();
        @(posedge ref_clk);
        elapsed++;
    endtask

    // Sets the direction level first, so channel B is settled at the event.
    task automatic fire(input logic rev, input logic signed [11:0] lvl, input int space);
        tick();
        mag_b <= rev ? HI : LO;
        repeat (20) tick();
        while (elapsed < space) tick();
        mag_a   <= lvl;
        elapsed = 0;
        repeat (50) tick();
        mag_a <= LO;
    endtask

    // Waits for one pulse and judges its width, class and mode, and its delay when lat is set.
    task automatic pulse(input wse_kind_t k, input int w, input logic fm, input logic lat);
        int          i;
        logic [15:0] n0;
        for (i = 0; i < 40000; i++) begin
            tick();
            @(negedge ref_clk);
            if (cur_high === 1'b1) break;
        end
        if (i == 40000) expire();
        n0 = pulse_cnt;
        if (lat) check(32'(elapsed >= PRE_GAP_CYC && elapsed <= PRE_GAP_CYC + 8), 32'h1);
        for (i = 0; i < 20000 && pulse_cnt === n0; i++) begin
            tick();
            @(negedge ref_clk);
        end
        if (i == 20000) expire();
        check(width, 32'(w));
        check(32'(kind), 32'(k));
        check({31'h0, fast_mode}, {31'h0, fm});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic sc_power_up();
        logic bad;
        bad = 1'b0;
        repeat (100) begin
            tick();
            @(negedge ref_clk);
            if (cur_high !== 1'b0 || fast_mode !== 1'b0) bad = 1'b1;
        end
        check({31'h0, bad}, 32'h0);
    endtask

    // Slow spacing: forward, reverse, forward again.
    task automatic sc_slow_dir();
        fire(1'b0, HI, 0);
        pulse(PK_FWD, FWD_CYC, 1'b0, 1'b1);
        fire(1'b1, HI, 10800);
        pulse(PK_REV, REV_CYC, 1'b0, 1'b1);
        fire(1'b0, HI, 15500);
        pulse(PK_FWD, FWD_CYC, 1'b0, 1'b1);
    endtask

    task automatic sc_fast_mode();
        fire(1'b0, HI, 9500);
        pulse(PK_FAST, FAST_CYC, 1'b1, 1'b1);
        fire(1'b0, HI, 8000);
        pulse(PK_FAST, FAST_CYC, 1'b1, 1'b1);
    endtask

    // Spacing between the two thresholds must keep fast mode.
    task automatic sc_hysteresis();
        fire(1'b1, HI, 10200);
        pulse(PK_FAST, FAST_CYC, 1'b1, 1'b1);
        fire(1'b0, HI, 10800);
        pulse(PK_FWD, FWD_CYC, 1'b0, 1'b1);
    endtask

    // Channel A parks at 55 percent of span, which must not be an event.
    task automatic sc_standstill();
        tick();
        mag_a <= 12'sh032;
        pulse(PK_STILL, STILL_W, 1'b0, 1'b0);
        pulse(PK_STILL, STILL_W, 1'b0, 1'b0);
        check(32'(period >= STILL_P - 4 && period <= STILL_P + 4), 32'h1);
    endtask

    // A rise to 62 percent of span is an event.
    task automatic sc_levels();
        fire(1'b0, 12'sh078, 0);
        pulse(PK_FWD, FWD_CYC, 1'b0, 1'b1);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        elapsed = 0;
        arst_n = 1'b0;
        mag_a = '0;
        mag_b = '0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        sc_power_up();
        sc_slow_dir();
        sc_fast_mode();
        sc_hysteresis();
        sc_standstill();
        sc_levels();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
